// *** dv/iod_host.sv ***
// Host model: drives register reads and writes on the block's request ports
`default_nettype none
module iod_host
   import iod_pkg::*;
(
   input  wire logic                 mclk,
   input  wire logic [15:0]          rd_data,
   input  wire logic                 rd_valid,
   output var  iod_pkg::iod_rd_req_t rd_req,
   output var  iod_pkg::iod_wr_req_t wr_req
);
   timeunit 1ns;
   timeprecision 1ns;

   // Idle request lines at time zero
   initial begin
      rd_req = '0;
      wr_req = '0;
   end

   // One read; ok stays low if no answer arrives within a few edges
   task automatic read(input logic [6:0] addr, output logic [15:0] data, output logic ok);
      int n;
      ok = 1'b0;
      data = 16'h0000;
      @(posedge mclk);
      #10 rd_req = '{en: 1'b1, addr: addr};
      @(posedge mclk);
      // Released address shows the inverse so a stale value is never reused
      #10 rd_req = '{en: 1'b0, addr: ~addr};
      for (n = 0; n < 4 && !ok; n++) begin
         @(posedge mclk);
         if (rd_valid === 1'b1) begin
            data = rd_data;
            ok = 1'b1;
         end
      end
      // Step off the edge so the caller never drives on it
      #10;
   endtask

   // One write pulse; the block answers nothing
   task automatic write(input logic [6:0] addr, input logic [15:0] data);
      @(posedge mclk);
      #10 wr_req = '{en: 1'b1, addr: addr, data: data};
      @(posedge mclk);
      #10 wr_req = '{en: 1'b0, addr: ~addr, data: ~data};
   endtask

   // Primary word extended by the top two secondary bits, 0.0625 mg a count
   function automatic logic [17:0] join18(input logic [15:0] pri, input logic [15:0] sec);
      return {pri, sec[15:14]};
   endfunction
endmodule
`default_nettype wire

// *** dv/tb_inertial_output_data_registers.sv ***
// Testbench of the inertial output data registers
`default_nettype none
module tb_inertial_output_data_registers;
   import iod_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;

   localparam int unsigned DIV = 8;      // Short internal sample period
   localparam int          EXT_GAP = 20; // External pin period in cycles

   logic        mclk;
   logic        resetn;
   logic [15:0] misc_control_word;
   logic [15:0] decimation_setting;
   logic        ext_sync_pin;
   logic        ext_run;                 // Lets the external pin toggle
   iod_accel_t  accel_in;
   logic [15:0] temp_in;
   logic        temp_valid;
   iod_rd_req_t rd_req;
   iod_wr_req_t wr_req;
   logic        sample_stb;
   logic        out_stb;
   logic [15:0] rd_data;
   logic        rd_valid;
   int          err_total = 0;
   int          num_checks = 0;
   logic [15:0] rv;
   logic [15:0] rv2;
   logic        ok;
   int          gap;
   logic [6:0]  ofs [6] = '{OFS_ACCZ_LOW, OFS_ACCZ, OFS_TEMP, OFS_DVX, OFS_DVY, OFS_DVZ};

   // Device under test
   iod_top #(.INT_DIV(DIV)) dut (
      .mclk(mclk), .resetn(resetn), .misc_control_word(misc_control_word),
      .decimation_setting(decimation_setting), .ext_sync_pin(ext_sync_pin),
      .accel_in(accel_in), .temp_in(temp_in), .temp_valid(temp_valid),
      .rd_req(rd_req), .wr_req(wr_req), .sample_stb(sample_stb),
      .out_stb(out_stb), .rd_data(rd_data), .rd_valid(rd_valid)
   );

   // Host on the register ports
   iod_host host (
      .mclk(mclk), .rd_data(rd_data), .rd_valid(rd_valid),
      .rd_req(rd_req), .wr_req(wr_req)
   );

   // 10 MHz clock
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end

   // External sample clock, still unless enabled
   initial begin
      ext_sync_pin = 1'b0;
      forever begin
         repeat (EXT_GAP / 2) @(posedge mclk);
         #10 ext_sync_pin = ext_run & ~ext_sync_pin;
      end
   end

   // Verdict and end of run
   task automatic end_of_test();
      if (err_total == 0 && num_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   // Compare seen against expected
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // Read one offset and compare
   task automatic rd_chk(input logic [6:0] addr, input logic [15:0] exp);
      host.read(addr, rv, ok);
      check($sformatf("answer %h", addr), {31'h0, ok}, 32'h0000_0001);
      check($sformatf("offset %h", addr), {16'h0, rv}, {16'h0, exp});
   endtask

   // Cycles between two successive pulses of a strobe
   task automatic stb_gap(input logic use_out, output int g);
      int n;
      int first;
      first = -1;
      g = -1;
      for (n = 0; n < 400 && g < 0; n++) begin
         @(posedge mclk);
         if ((use_out ? out_stb : sample_stb) === 1'b1) begin
            if (first >= 0) g = n - first;
            else first = n;
         end
      end
      #10;
      if (g < 0) begin
         err_total++;
         end_of_test();
      end
   endtask

   // Main sequence
   initial begin
      resetn = 1'b0;
      misc_control_word = 16'h0000;
      decimation_setting = 16'h0000;
      ext_run = 1'b0;
      accel_in = '0;
      temp_in = 16'h0000;
      temp_valid = 1'b0;
      repeat (20) @(posedge mclk);
      #10 resetn = 1'b1;
      // Reset contents and an unmapped offset
      foreach (ofs[i]) rd_chk(ofs[i], DATA_RST);
      rd_chk(7'h30, UNMAPPED);
      // Temperature load, then a write that must not land
      @(posedge mclk);
      #10 temp_in = 16'hFAEC;
      temp_valid = 1'b1;
      @(posedge mclk);
      #10 temp_valid = 1'b0;
      temp_in = 16'h0640;
      rd_chk(OFS_TEMP, 16'hFAEC);
      rd_chk(7'h1F, 16'hFAEC);
      host.write(OFS_TEMP, 16'h1234);
      rd_chk(OFS_TEMP, 16'hFAEC);
      // Internal rate, no decimation
      accel_in = '{x: 16'h4E20, y: 16'hFFFF, z: 32'hB1E0_4000};
      stb_gap(1'b0, gap);
      check("sample gap", gap, DIV);
      stb_gap(1'b1, gap);
      check("output gap", gap, DIV);
      repeat (40) @(posedge mclk);
      rd_chk(OFS_ACCZ, 16'hB1E0);
      rd_chk(OFS_ACCZ_LOW, 16'h4000);
      host.read(OFS_ACCZ, rv2, ok);
      check("z 18 bit", host.join18(rv2, rv), 32'h0002_C781);
      rd_chk(OFS_DVX, 16'h4E20);
      rd_chk(OFS_DVY, 16'hFFFF);
      rd_chk(OFS_DVZ, 16'hB1E0);
      host.write(OFS_DVX, 16'h1234);
      host.write(OFS_ACCZ, 16'h1234);
      rd_chk(OFS_DVX, 16'h4E20);
      rd_chk(OFS_ACCZ, 16'hB1E0);
      // Decimation by four, most negative value
      decimation_setting = 16'h0003;
      accel_in.x = 16'h8000;
      stb_gap(1'b1, gap);
      check("decimated gap", gap, 4 * DIV);
      repeat (40) @(posedge mclk);
      rd_chk(OFS_DVX, 16'h8000);
      // External clock for every non-internal select code
      decimation_setting = 16'h0000;
      ext_run = 1'b1;
      for (int s = 1; s < 4; s++) begin
         misc_control_word = 16'(s) << CLKSEL_LSB;
         stb_gap(1'b0, gap);
         check($sformatf("ext gap sel %0d", s), gap, EXT_GAP);
      end
      accel_in.y = 16'h0002;
      stb_gap(1'b1, gap);
      repeat (40) @(posedge mclk);
      rd_chk(OFS_DVY, 16'h0002);
      // Back to the internal rate
      misc_control_word = 16'h0000;
      ext_run = 1'b0;
      stb_gap(1'b0, gap);
      check("internal again", gap, DIV);
      end_of_test();
   end
endmodule
`default_nettype wire

// *** logic/iod_dv_accum.sv ***
// Per-axis delta velocity accumulator with decimation scaling
`default_nettype none
module iod_dv_accum
   import iod_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        resetn,
   input  wire logic        sample_stb,
   input  wire logic        out_stb,
   input  wire logic [15:0] dec,
   input  wire logic [15:0] accel,
   output logic [15:0]      dv,
   output logic             dv_valid
);
   logic signed [31:0] sum_r;     // Running sum of samples
   logic [31:0]        quo_r;     // Dividend shifting into quotient
   logic [16:0]        rem_r;     // Partial remainder
   logic [16:0]        den_r;     // Decimation + 1
   logic               neg_r;     // Sign of the sum
   logic [5:0]         step_r;    // Steps done
   iod_dv_state_t      st_r;
   wire signed [31:0]  sum_nxt = sum_r + 32'(signed'(accel));
   wire [17:0]         rem_sh  = {rem_r, quo_r[31]};
   wire                fits    = (rem_sh >= {1'b0, den_r});
   wire [17:0]         rem_sub = rem_sh - {1'b0, den_r};
   wire                ovf     = |quo_r[31:15];
   wire [15:0]         mag     = quo_r[15:0];

   // Sum one output cycle, then divide by decimation + 1
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         sum_r    <= 32'h0000_0000;
         quo_r    <= 32'h0000_0000;
         rem_r    <= 17'h0_0000;
         den_r    <= 17'h0_0001;
         neg_r    <= 1'b0;
         step_r   <= 6'h00;
         st_r     <= DV_IDLE;
         dv       <= DATA_RST;
         dv_valid <= 1'b0;
      end else begin
         dv_valid <= 1'b0;
         if (sample_stb) begin
            sum_r <= out_stb ? 32'h0000_0000 : sum_nxt;
         end
         case (st_r)
            DV_IDLE: begin
               if (out_stb) begin
                  neg_r  <= sum_nxt[31];
                  quo_r  <= sum_nxt[31] ? 32'(-sum_nxt) : sum_nxt;
                  rem_r  <= 17'h0_0000;
                  den_r  <= {1'b0, dec} + 17'h0_0001;
                  step_r <= 6'h00;
                  st_r   <= DV_RUN;
               end
            end
            DV_RUN: begin
               quo_r  <= {quo_r[30:0], fits};
               rem_r  <= fits ? rem_sub[16:0] : rem_sh[16:0];
               step_r <= step_r + 6'h01;
               if (step_r == DIV_STEPS - 6'h01) begin
                  st_r <= DV_DONE;
               end
            end
            DV_DONE: begin
               // Saturate to the 16-bit two's complement range
               if (neg_r) begin
                  dv <= (ovf && mag != SAT_NEG) ? SAT_NEG : 16'(-mag);
               end else begin
                  dv <= ovf ? SAT_POS : mag;
               end
               dv_valid <= 1'b1;
               st_r     <= DV_IDLE;
            end
            default: st_r <= DV_IDLE;
         endcase
      end
   end

   a_dv_latency: assert property (@(posedge mclk) disable iff (!resetn)
      st_r == DV_IDLE && out_stb |-> ##34 dv_valid)
      else $error("delta velocity not ready 34 cycles after output cycle");
endmodule
`default_nettype wire

// *** logic/iod_pkg.sv ***
// Shared constants and types of the inertial output data block
`default_nettype none
package iod_pkg;
   // Clock and internal sample rate
   localparam int unsigned MCLK_HZ       = 10_000_000;
   localparam int unsigned SAMPLE_HZ_INT = 2048;
   // Cycles per internal sample period, rounded down
   localparam int unsigned INT_DIV_CYC   = MCLK_HZ / SAMPLE_HZ_INT;
   // Register byte offsets
   localparam logic [6:0] OFS_ACCZ_LOW = 7'h18;
   localparam logic [6:0] OFS_ACCZ     = 7'h1A;
   localparam logic [6:0] OFS_TEMP     = 7'h1E;
   localparam logic [6:0] OFS_DVX      = 7'h2A;
   localparam logic [6:0] OFS_DVY      = 7'h2C;
   localparam logic [6:0] OFS_DVZ      = 7'h2E;
   // Value of every output data register after reset
   localparam logic [15:0] DATA_RST    = 16'h0000;
   // Value read from an unmapped offset
   localparam logic [15:0] UNMAPPED    = 16'h0000;
   // Sample clock select field position and internal code
   localparam int unsigned CLKSEL_LSB  = 2;
   localparam logic [1:0]  CLKSEL_INT  = 2'h0;
   // Divider steps for the delta velocity scaling
   localparam logic [5:0]  DIV_STEPS   = 6'h20;
   // Saturation limits of a 16-bit two's complement word
   localparam logic [15:0] SAT_POS     = 16'h7FFF;
   localparam logic [15:0] SAT_NEG     = 16'h8000;

   // One sample of calibrated acceleration from the measurement path
   typedef struct packed {
      logic [15:0] x;   // Primary word, x axis
      logic [15:0] y;   // Primary word, y axis
      logic [31:0] z;   // Primary word over secondary word, z axis
   } iod_accel_t;

   // Register read request
   typedef struct packed {
      logic       en;
      logic [6:0] addr;
   } iod_rd_req_t;

   // Register write request
   typedef struct packed {
      logic        en;
      logic [6:0]  addr;
      logic [15:0] data;
   } iod_wr_req_t;

   // Divider sequencing
   typedef enum logic [1:0] {
      DV_IDLE = 2'b00,
      DV_RUN  = 2'b01,
      DV_DONE = 2'b10
   } iod_dv_state_t;
endpackage
`default_nettype wire

// *** logic/iod_rate_gen.sv ***
// Sample strobe selection and decimation counter
`default_nettype none
module iod_rate_gen
   import iod_pkg::*;
#(
   parameter int unsigned INT_DIV = INT_DIV_CYC
) (
   input  wire logic        mclk,
   input  wire logic        resetn,
   input  wire logic [1:0]  clk_sel,
   input  wire logic [15:0] dec,
   input  wire logic        ext_rise,
   output logic             sample_stb,
   output logic             out_stb
);
   localparam logic [12:0] DIV_LAST = 13'(INT_DIV - 1);
   logic [12:0] div_r;        // Internal rate divider
   logic [15:0] dec_r;        // Samples taken in this output cycle
   wire         int_tick = (div_r == DIV_LAST);
   wire         use_int  = (clk_sel == CLKSEL_INT);

   // Internal 2048 Hz rate or external edge, by select field
   assign sample_stb = use_int ? int_tick : ext_rise;
   // Output cycle ends on the last of decimation + 1 samples
   assign out_stb    = sample_stb && (dec_r >= dec);

   // Free running internal divider
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         div_r <= 13'h0000;
      end else begin
         div_r <= int_tick ? 13'h0000 : div_r + 13'h0001;
      end
   end

   // Decimation counter
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         dec_r <= 16'h0000;
      end else if (sample_stb) begin
         dec_r <= out_stb ? 16'h0000 : dec_r + 16'h0001;
      end
   end

   a_int_rate_sel: assert property (@(posedge mclk) disable iff (!resetn)
      use_int && int_tick |-> sample_stb)
      else $error("internal tick lost with internal select");
   a_ext_rate_sel: assert property (@(posedge mclk) disable iff (!resetn)
      !use_int |-> (sample_stb == ext_rise))
      else $error("sample strobe not from external edge");
endmodule
`default_nettype wire

// *** logic/iod_top.sv ***
// Inertial output data registers: acceleration, delta velocity, temperature
`default_nettype none
module iod_top
   import iod_pkg::*;
#(
   parameter int unsigned INT_DIV = INT_DIV_CYC // Cycles per internal sample
) (
   input  wire logic                 mclk,
   input  wire logic                 resetn,
   input  wire logic [15:0]          misc_control_word,
   input  wire logic [15:0]          decimation_setting,
   input  wire logic                 ext_sync_pin,
   input  wire iod_pkg::iod_accel_t  accel_in,
   input  wire logic [15:0]          temp_in,
   input  wire logic                 temp_valid,
   input  wire iod_pkg::iod_rd_req_t rd_req,
   input  wire iod_pkg::iod_wr_req_t wr_req,
   output logic                      sample_stb,
   output logic                      out_stb,
   output logic [15:0]               rd_data,
   output logic                      rd_valid
);
   import iod_pkg::*;

   // Word match: odd byte addresses select the same word
   function automatic logic hit(input logic [6:0] a, input logic [6:0] ofs);
      hit = (a[6:1] == ofs[6:1]);
   endfunction

   // External sync pin synchroniser and edge detect
   logic        sync1_r;         // First stage, read only by second
   logic        sync2_r;         // Second stage
   logic        sync3_r;         // Delayed copy for edge detect
   wire         ext_rise = sync2_r && !sync3_r;

   // Output data registers
   logic [15:0] accz_pri_r;      // Z acceleration, primary word
   logic [15:0] accz_low_r;      // Z acceleration, secondary word
   logic [15:0] temp_r;          // Internal temperature
   logic [15:0] dv_r [3];        // Delta velocity per axis
   logic [15:0] dv_w [3];        // Scaled results from accumulators
   logic [2:0]  dv_vld;          // Result strobes from accumulators
   wire  [15:0] acc_ax [3];      // Primary acceleration per axis

   // Sample clock select field from the misc control word
   wire  [1:0]  clk_sel = misc_control_word[CLKSEL_LSB +: 2];

   assign acc_ax[0] = accel_in.x;
   assign acc_ax[1] = accel_in.y;
   assign acc_ax[2] = accel_in.z[31:16];

   // Two flip-flops before any logic reads the pin
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         sync1_r <= 1'b0;
         sync2_r <= 1'b0;
         sync3_r <= 1'b0;
      end else begin
         sync1_r <= ext_sync_pin;
         sync2_r <= sync1_r;
         sync3_r <= sync2_r;
      end
   end

   // Sample and output cycle strobes
   iod_rate_gen #(
      .INT_DIV    (INT_DIV)
   ) u_rate (
      .mclk       (mclk),
      .resetn     (resetn),
      .clk_sel    (clk_sel),
      .dec        (decimation_setting),
      .ext_rise   (ext_rise),
      .sample_stb (sample_stb),
      .out_stb    (out_stb)
   );

   // One accumulator per axis
   generate
      for (genvar i = 0; i < 3; i++) begin : g_axis
         iod_dv_accum u_dv (
            .mclk       (mclk),
            .resetn     (resetn),
            .sample_stb (sample_stb),
            .out_stb    (out_stb),
            .dec        (decimation_setting),
            .accel      (acc_ax[i]),
            .dv         (dv_w[i]),
            .dv_valid   (dv_vld[i])
         );
      end
   endgenerate

   // Result of each output cycle lands in its own register; one process
   // drives the whole array so no element has two drivers
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         for (int k = 0; k < 3; k++) begin
            dv_r[k] <= DATA_RST;
         end
      end else begin
         for (int k = 0; k < 3; k++) begin
            if (dv_vld[k]) begin
               dv_r[k] <= dv_w[k];
            end
         end
      end
   end

   // Acceleration words refresh at the end of each output cycle
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         accz_pri_r <= DATA_RST;
         accz_low_r <= DATA_RST;
      end else if (out_stb) begin
         accz_pri_r <= accel_in.z[31:16];
         accz_low_r <= accel_in.z[15:0];
      end
   end

   // Temperature loads whenever a measurement arrives
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         temp_r <= DATA_RST;
      end else if (temp_valid) begin
         temp_r <= temp_in;
      end
   end

   // Read decode
   wire         sel_accz_low = hit(rd_req.addr, OFS_ACCZ_LOW);
   wire         sel_accz     = hit(rd_req.addr, OFS_ACCZ);
   wire         sel_temp     = hit(rd_req.addr, OFS_TEMP);
   wire         sel_dvx      = hit(rd_req.addr, OFS_DVX);
   wire         sel_dvy      = hit(rd_req.addr, OFS_DVY);
   wire         sel_dvz      = hit(rd_req.addr, OFS_DVZ);
   wire [15:0]  rd_mux =
      sel_accz     ? accz_pri_r :
      sel_accz_low ? accz_low_r :
      sel_temp     ? temp_r     :
      sel_dvx      ? dv_r[0]    :
      sel_dvy      ? dv_r[1]    :
      sel_dvz      ? dv_r[2]    :
      UNMAPPED;

   // Registered read answer, one cycle after the request
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         rd_data  <= DATA_RST;
         rd_valid <= 1'b0;
      end else begin
         rd_valid <= rd_req.en;
         if (rd_req.en) begin
            rd_data <= rd_mux;
         end
      end
   end

   // Writes are accepted on the port and dropped here: no process
   // above reads wr_req, so the measurement path alone sets contents.
   wire         wr_hit = wr_req.en && (hit(wr_req.addr, OFS_ACCZ)
                         || hit(wr_req.addr, OFS_TEMP)
                         || hit(wr_req.addr, OFS_DVX));

   // Check helpers: cycles and samples counted apart from the rate
   // generator, so its divider and decimation counter are cross-checked
   wire         int_sel = (clk_sel == CLKSEL_INT); // Internal rate selected
   logic [12:0] gap_r;           // Cycles since the last sample
   logic        gap_ok_r;        // Whole gap spent on the internal rate
   logic [15:0] smp_r;           // Samples since the last output cycle
   logic [15:0] dec_seen_r;      // Decimation setting one cycle ago
   logic        dec_ok_r;        // Decimation steady since last output cycle

   // Sample spacing under the internal rate
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         gap_r    <= 13'h0000;
         gap_ok_r <= 1'b0;
      end else if (sample_stb) begin
         gap_r    <= 13'h0000;
         gap_ok_r <= int_sel;
      end else begin
         gap_r    <= gap_r + 13'h0001;
         gap_ok_r <= gap_ok_r && int_sel;
      end
   end

   // Samples per output cycle while the decimation setting holds
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         smp_r      <= 16'h0000;
         dec_seen_r <= DATA_RST;
         dec_ok_r   <= 1'b1;
      end else begin
         dec_seen_r <= decimation_setting;
         if (out_stb) begin
            smp_r    <= 16'h0000;
            dec_ok_r <= 1'b1;
         end else begin
            if (sample_stb) begin
               smp_r <= smp_r + 16'h0001;
            end
            dec_ok_r <= dec_ok_r && (decimation_setting == dec_seen_r);
         end
      end
   end

   // Checks
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!resetn);

   a_write_ignored: assert property (
      wr_hit && !out_stb && !temp_valid && !(|dv_vld)
      |=> $stable(accz_pri_r) && $stable(temp_r) && $stable(dv_r[0]))
      else $error("write changed an output data register");
   a_accz_load: assert property (
      out_stb |=> accz_pri_r == $past(accel_in.z[31:16]))
      else $error("z primary word not loaded at output cycle");
   a_accz_split: assert property (
      out_stb |=> {accz_pri_r, accz_low_r} == $past(accel_in.z))
      else $error("z primary and secondary words do not form the sample");
   a_accz_read: assert property (
      rd_req.en && rd_req.addr == OFS_ACCZ && !out_stb
      |=> rd_valid && rd_data == accz_pri_r)
      else $error("read of 0x1A did not return z primary word");
   a_temp_read: assert property (
      rd_req.en && rd_req.addr == OFS_TEMP && !temp_valid
      |=> rd_valid && rd_data == temp_r)
      else $error("read of 0x1E did not return temperature");
   a_temp_load: assert property (
      temp_valid ##1 !temp_valid |-> temp_r == $past(temp_in, 1) ##1 $stable(temp_r))
      else $error("temperature register not holding last sample");
   a_dvx_read: assert property (
      rd_req.en && rd_req.addr == OFS_DVX && !dv_vld[0]
      |=> rd_data == dv_r[0])
      else $error("read of 0x2A did not return x delta velocity");
   a_dvy_read: assert property (
      rd_req.en && rd_req.addr == OFS_DVY && !dv_vld[1]
      |=> rd_data == dv_r[1])
      else $error("read of 0x2C did not return y delta velocity");
   a_dvz_read: assert property (
      rd_req.en && rd_req.addr == OFS_DVZ && !dv_vld[2]
      |=> rd_data == dv_r[2])
      else $error("read of 0x2E did not return z delta velocity");
   a_dv_update: assert property (
      dv_vld[1] |=> dv_r[1] == $past(dv_w[1]))
      else $error("delta velocity register missed its result");
   a_unmapped_read: assert property (
      rd_req.en && !(sel_accz || sel_accz_low || sel_temp || sel_dvx
                     || sel_dvy || sel_dvz)
      |=> rd_data == UNMAPPED)
      else $error("unmapped read did not return zero");
   a_sync_edge: assert property (
      clk_sel != CLKSEL_INT && $rose(sync2_r) |-> sample_stb)
      else $error("external edge did not produce a sample");

   // Holds, read answers and rate cross-checks
   a_int_period: assert property (
      int_sel && sample_stb && gap_ok_r |-> gap_r == 13'(INT_DIV - 1))
      else $error("internal sample period wrong");
   a_dec_count: assert property (
      sample_stb && dec_ok_r && decimation_setting == dec_seen_r
      |-> out_stb == (smp_r == decimation_setting))
      else $error("output cycle not on the last of decimation plus one samples");
   a_accz_hold: assert property (
      !out_stb |=> $stable(accz_pri_r) && $stable(accz_low_r))
      else $error("z acceleration changed outside an output cycle");
   a_temp_hold: assert property (
      !temp_valid |=> $stable(temp_r))
      else $error("temperature changed without a measurement");
   a_dv_hold: assert property (
      !(|dv_vld) |=> $stable(dv_r[0]) && $stable(dv_r[1]) && $stable(dv_r[2]))
      else $error("delta velocity changed without a result");
   a_low_read: assert property (
      rd_req.en && rd_req.addr == OFS_ACCZ_LOW && !out_stb
      |=> rd_valid && rd_data == accz_low_r)
      else $error("read of 0x18 did not return z secondary word");
   a_odd_read: assert property (
      rd_req.en && rd_req.addr == (OFS_TEMP | 7'h01) && !temp_valid
      |=> rd_valid && rd_data == temp_r)
      else $error("odd byte address did not select the temperature word");
   a_rd_answer: assert property (
      rd_req.en |=> rd_valid)
      else $error("read request got no answer");
   a_rd_quiet: assert property (
      !rd_req.en |=> !rd_valid && $stable(rd_data))
      else $error("answer or data change without a read request");
   a_out_sample: assert property (
      out_stb |-> sample_stb)
      else $error("output cycle ended without a sample");
   a_sync_chain: assert property (
      sync2_r == $past(sync1_r) && sync3_r == $past(sync2_r))
      else $error("pin synchroniser skipped a stage");
endmodule
`default_nettype wire
